//--- hw/uarf_params.svh
// register offsets, field positions, reset values and rate divisors
`ifndef UARF_PARAMS_SVH
`define UARF_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define UARF_ADDR_POWER_CONTROL_REG 8'h87
`define UARF_ADDR_SERIAL_CONTROL_REG 8'h98
`define UARF_ADDR_SBUF 8'h99
`define UARF_ADDR_BAUD_CONTROL_REG 8'h9b
`define UARF_ADDR_SLAVE_ADDRESS 8'ha9
`define UARF_ADDR_SLAVE_ADDRESS_MASK 8'hb9
`define UARF_ADDR_IRQ_STAT 8'hc0
`define UARF_ADDR_IRQ_MASK 8'hc1
`define UARF_ADDR_TIMING 8'hc2

// ************************************************************
// field positions
// ************************************************************
`define UARF_SC_BIT7 7
`define UARF_SC_SM1 6
`define UARF_SC_MPE 5
`define UARF_SC_REN 4
`define UARF_SC_TB8 3
`define UARF_SC_RB8 2
`define UARF_SC_TI 1
`define UARF_SC_RI 0
`define UARF_PC_DOUBLE 7
`define UARF_PC_VIEW 6
`define UARF_BD_SRC 0
`define UARF_IRQ_RX 0
`define UARF_IRQ_TX 1
`define UARF_IRQ_FE 2

// ************************************************************
// reset values
// ************************************************************
`define UARF_RST_ADDR 8'h00
`define UARF_RST_MASK 8'h00
`define UARF_RST_BAUD_CONTROL_REG 5'h00

// ************************************************************
// mode 0 rate divisors and receive timing
// ************************************************************
`define UARF_DIV_FAST_SLOW 3'h4
`define UARF_DIV_FAST_DBL 3'h2
`define UARF_DIV_COMP_SLOW 3'h6
`define UARF_DIV_COMP_DBL 3'h3
`define UARF_DIV_T1_SLOW 3'h4
`define UARF_DIV_T1_DBL 3'h2
`define UARF_DIV_BRG_SLOW 3'h2
`define UARF_DIV_BRG_DBL 3'h1
`define UARF_M0_BITS 4'h8
`define UARF_SAMP_A 4'h7
`define UARF_SAMP_C 4'h9
`define UARF_SAMP_LAST 4'hf

`endif

//--- hw/uarf_pkg.sv
// types shared by the serial port receive extensions
package uarf_pkg;

  typedef enum logic [1:0] {
    UARF_MODE0 = 2'b00,
    UARF_MODE1 = 2'b01,
    UARF_MODE2 = 2'b10,
    UARF_MODE3 = 2'b11
  } uarf_mode_e;

  typedef enum logic [1:0] {
    UARF_RX_IDLE = 2'b00,
    UARF_RX_START = 2'b01,
    UARF_RX_DATA = 2'b10,
    UARF_RX_STOP = 2'b11
  } uarf_rxst_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uarf_bus_req_s;

endpackage

//--- hw/uarf_core.sv
// serial port with framing error, address recognition and mode 0 rates
//
// Functional notes
// - missing stop bit sets framing error flag
// - control bit 7 view chosen by view select
// - framing error flag cleared only by software
// - framing error set whatever the view select
// - filtering only with enable in modes 1-3
// - mode 0 receive never gated by matching
// - nine-bit filter: ninth bit one, valid stop and match
// - mode 1 filter: valid stop and match
// - given match compares only masked bits
// - broadcast is address OR mask, zeros ignored
// - reset clears slave address and mask
// - mode 0 half duplex, data on rxd pin
// - mode 0 moves eight bits lsb first
// - fast mode 0 rate clock/4 or /2
// - compatibility mode 0 rate clock/6 or /3
// - timer overflow source divided by 4 or 2
// - generator overflow divided by 2 or 1
// - mode 1 load needs clear flag; stop only under filtering
`include "uarf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module uarf_core
  import uarf_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire uarf_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic rx_tick16,
  input wire logic timer1_ovf,
  input wire logic brg_ovf,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe,
  output logic txd_o,
  output logic irq
);

  // ************************************************************
  // register state
  // ************************************************************
  logic sm0_reg, fe_reg, sm1_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg;
  logic ti_reg, ri_reg;
  logic [7:0] power_control_reg_reg, slave_address_reg, slave_address_mask_reg, sbuf_reg, rdata_reg;
  logic [4:0] baud_control_reg_reg;
  logic [2:0] stat_reg, mask_reg;
  logic compat_reg;
  logic wr_serial_control_reg, wr_sbuf;
  uarf_mode_e mode;

  assign wr_serial_control_reg = bus_req.wr && (bus_req.addr == `UARF_ADDR_SERIAL_CONTROL_REG);
  assign wr_sbuf = bus_req.wr && (bus_req.addr == `UARF_ADDR_SBUF);
  assign mode = uarf_mode_e'({sm0_reg, sm1_reg});

  // ************************************************************
  // input synchroniser
  // ************************************************************
  logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= rxd_i;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  // ************************************************************
  // frame receiver, modes 1 to 3
  // ************************************************************
  uarf_rxst_e rx_state_reg;
  logic [3:0] samp_cnt_reg, bit_cnt_reg, last_bit;
  logic [1:0] votes_reg;
  logic [8:0] rx_shift_reg;
  logic rx_stop_reg, rx_final_reg, bit_end, bit_val, start_edge;

  assign start_edge = rxd_prev_reg && !rxd_sync_reg && ren_reg
                      && (mode != UARF_MODE0);
  assign bit_end = rx_tick16 && (samp_cnt_reg == `UARF_SAMP_LAST);
  // two of three samples decide the bit
  assign bit_val = (votes_reg >= 2'h2);
  assign last_bit = (mode == UARF_MODE1) ? 4'h7 : 4'h8;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_state_reg <= UARF_RX_IDLE;
      samp_cnt_reg <= 4'h0;
      votes_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 9'h1ff;
      rx_stop_reg <= 1'b1;
      rx_final_reg <= 1'b0;
    end
    else
    begin
      rx_final_reg <= 1'b0;
      if (rx_state_reg == UARF_RX_IDLE)
      begin
        if (start_edge)
        begin
          rx_state_reg <= UARF_RX_START;
          samp_cnt_reg <= 4'h0;
          votes_reg <= 2'h0;
          bit_cnt_reg <= 4'h0;
          rx_shift_reg <= 9'h1ff;
        end
      end
      else if (rx_tick16)
      begin
        samp_cnt_reg <= samp_cnt_reg + 4'h1;
        if (samp_cnt_reg >= `UARF_SAMP_A && samp_cnt_reg <= `UARF_SAMP_C)
          votes_reg <= votes_reg + {1'b0, rxd_sync_reg};
        if (bit_end)
        begin
          votes_reg <= 2'h0;
          case (rx_state_reg)
            UARF_RX_START:
              rx_state_reg <= bit_val ? UARF_RX_IDLE : UARF_RX_DATA;
            UARF_RX_DATA:
            begin
              rx_shift_reg[bit_cnt_reg] <= bit_val;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == last_bit)
                rx_state_reg <= UARF_RX_STOP;
            end
            UARF_RX_STOP:
            begin
              rx_stop_reg <= bit_val;
              rx_final_reg <= 1'b1;
              rx_state_reg <= UARF_RX_IDLE;
            end
            default:
              rx_state_reg <= UARF_RX_IDLE;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // address recognition
  // ************************************************************
  logic [7:0] rx_byte;
  logic rx_ninth, filt_on, given_hit, bcast_hit, addr_hit, rx_load, fe_set;

  assign rx_byte = rx_shift_reg[7:0];
  // mode 1 has no ninth data bit, the stop bit stands in
  assign rx_ninth = (mode == UARF_MODE1) ? rx_stop_reg : rx_shift_reg[8];
  assign filt_on = mpe_reg && (mode != UARF_MODE0);
  assign given_hit = (((rx_byte ^ slave_address_reg) & slave_address_mask_reg) == 8'h00);
  assign bcast_hit = (((~rx_byte) & (slave_address_reg | slave_address_mask_reg)) == 8'h00);
  assign addr_hit = given_hit || bcast_hit;
  // load gating
  // nine-bit modes also want a valid stop bit under filtering
  assign rx_load = rx_final_reg && !ri_reg
                   && (!filt_on || (rx_ninth && addr_hit && rx_stop_reg));
  assign fe_set = rx_final_reg && !rx_stop_reg;

  // ************************************************************
  // mode 0 rate generation
  // ************************************************************
  logic src_tick, m0_tick;
  logic [2:0] div_sel, div_cnt_reg;

  always_comb
  begin
    if (baud_control_reg_reg[`UARF_BD_SRC])
    begin
      src_tick = brg_ovf;
      div_sel = power_control_reg_reg[`UARF_PC_DOUBLE] ? `UARF_DIV_BRG_DBL
                                          : `UARF_DIV_BRG_SLOW;
    end
    else if (tb8_reg)
    begin
      src_tick = timer1_ovf;
      div_sel = power_control_reg_reg[`UARF_PC_DOUBLE] ? `UARF_DIV_T1_DBL
                                          : `UARF_DIV_T1_SLOW;
    end
    else if (compat_reg)
    begin
      src_tick = 1'b1;
      div_sel = power_control_reg_reg[`UARF_PC_DOUBLE] ? `UARF_DIV_COMP_DBL
                                          : `UARF_DIV_COMP_SLOW;
    end
    else
    begin
      src_tick = 1'b1;
      div_sel = power_control_reg_reg[`UARF_PC_DOUBLE] ? `UARF_DIV_FAST_DBL
                                          : `UARF_DIV_FAST_SLOW;
    end
  end

  // counter may exceed a freshly lowered divisor; the >= wraps it
  assign m0_tick = src_tick && (div_cnt_reg >= div_sel - 3'h1);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      div_cnt_reg <= 3'h0;
    else if (m0_tick)
      div_cnt_reg <= 3'h0;
    else if (src_tick)
      div_cnt_reg <= div_cnt_reg + 3'h1;
  end

  // ************************************************************
  // mode 0 shifter
  // ************************************************************
  logic m0_busy_reg, m0_tx_reg, m0_low_reg, m0_tx_done, m0_rx_done;
  logic m0_tx_start, m0_rx_start;
  logic [3:0] m0_cnt_reg;
  logic [7:0] m0_sh_reg;

  assign m0_tx_start = wr_sbuf && (mode == UARF_MODE0) && !m0_busy_reg;
  assign m0_rx_start = (mode == UARF_MODE0) && ren_reg && !ri_reg
                       && !m0_busy_reg && !m0_tx_start;
  assign m0_tx_done = m0_busy_reg && m0_tx_reg && !m0_low_reg && m0_tick
                      && (m0_cnt_reg == `UARF_M0_BITS);
  assign m0_rx_done = m0_busy_reg && !m0_tx_reg && !m0_low_reg && m0_tick
                      && (m0_cnt_reg == `UARF_M0_BITS);

  // half duplex, lsb first, eight bits
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      m0_busy_reg <= 1'b0;
      m0_tx_reg <= 1'b0;
      m0_low_reg <= 1'b0;
      m0_cnt_reg <= 4'h0;
      m0_sh_reg <= 8'hff;
    end
    else if (!m0_busy_reg)
    begin
      m0_low_reg <= 1'b0;
      m0_cnt_reg <= 4'h0;
      if (m0_tx_start || m0_rx_start)
      begin
        m0_busy_reg <= 1'b1;
        m0_tx_reg <= m0_tx_start;
        m0_sh_reg <= m0_tx_start ? bus_req.wdata : 8'hff;
      end
    end
    else if (m0_low_reg)
    begin
      // clock rises here; sampled data lags the pin by the synchroniser
      m0_low_reg <= 1'b0;
      m0_sh_reg <= {m0_tx_reg ? 1'b0 : rxd_sync_reg, m0_sh_reg[7:1]};
      m0_cnt_reg <= m0_cnt_reg + 4'h1;
    end
    else if (m0_tick)
    begin
      if (m0_cnt_reg == `UARF_M0_BITS)
        m0_busy_reg <= 1'b0;
      else
        m0_low_reg <= 1'b1;
    end
  end

  assign txd_o = (mode == UARF_MODE0) ? ~m0_low_reg : 1'b1;
  assign rxd_o = m0_sh_reg[0];
  assign rxd_oe = m0_busy_reg && m0_tx_reg;

  // ************************************************************
  // serial control register
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sm0_reg <= 1'b0;
      sm1_reg <= 1'b0;
      mpe_reg <= 1'b0;
      ren_reg <= 1'b0;
      tb8_reg <= 1'b0;
    end
    else if (wr_serial_control_reg)
    begin
      if (!power_control_reg_reg[`UARF_PC_VIEW])
        sm0_reg <= bus_req.wdata[`UARF_SC_BIT7];
      sm1_reg <= bus_req.wdata[`UARF_SC_SM1];
      mpe_reg <= bus_req.wdata[`UARF_SC_MPE];
      ren_reg <= bus_req.wdata[`UARF_SC_REN];
      tb8_reg <= bus_req.wdata[`UARF_SC_TB8];
    end
  end

  // set in any view, software clear only
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      fe_reg <= 1'b0;
    else if (fe_set)
      fe_reg <= 1'b1;
    else if (wr_serial_control_reg && power_control_reg_reg[`UARF_PC_VIEW])
      fe_reg <= bus_req.wdata[`UARF_SC_BIT7];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ri_reg <= 1'b0;
      ti_reg <= 1'b0;
      rb8_reg <= 1'b0;
      sbuf_reg <= 8'h00;
    end
    else
    begin
      ri_reg <= rx_load || m0_rx_done
                || (wr_serial_control_reg ? bus_req.wdata[`UARF_SC_RI] : ri_reg);
      ti_reg <= m0_tx_done
                || (wr_serial_control_reg ? bus_req.wdata[`UARF_SC_TI] : ti_reg);
      if (rx_load)
      begin
        sbuf_reg <= rx_byte;
        rb8_reg <= rx_ninth;
      end
      else if (m0_rx_done)
        sbuf_reg <= m0_sh_reg;
      else if (wr_serial_control_reg)
        rb8_reg <= bus_req.wdata[`UARF_SC_RB8];
    end
  end

  // ************************************************************
  // other registers
  // ************************************************************
  // address and mask reset
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      slave_address_reg <= `UARF_RST_ADDR;
      slave_address_mask_reg <= `UARF_RST_MASK;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `UARF_ADDR_SLAVE_ADDRESS)
        slave_address_reg <= bus_req.wdata;
      if (bus_req.addr == `UARF_ADDR_SLAVE_ADDRESS_MASK)
        slave_address_mask_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      power_control_reg_reg <= 8'h00;
      baud_control_reg_reg <= `UARF_RST_BAUD_CONTROL_REG;
      mask_reg <= 3'h0;
      compat_reg <= 1'b0;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `UARF_ADDR_POWER_CONTROL_REG)
        power_control_reg_reg <= bus_req.wdata;
      if (bus_req.addr == `UARF_ADDR_BAUD_CONTROL_REG)
        baud_control_reg_reg <= bus_req.wdata[4:0];
      if (bus_req.addr == `UARF_ADDR_IRQ_MASK)
        mask_reg <= bus_req.wdata[2:0];
      if (bus_req.addr == `UARF_ADDR_TIMING)
        compat_reg <= bus_req.wdata[0];
    end
  end

  // sticky events; a new event wins over a write-one clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      stat_reg <= 3'h0;
    else
      stat_reg <= {fe_set, m0_tx_done, rx_load || m0_rx_done}
                  | (stat_reg & ~((bus_req.wr
                     && bus_req.addr == `UARF_ADDR_IRQ_STAT)
                     ? bus_req.wdata[2:0] : 3'h0));
  end

  assign irq = |(stat_reg & mask_reg);

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_reg <= 8'h00;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        `UARF_ADDR_SERIAL_CONTROL_REG:
          rdata_reg <= {power_control_reg_reg[`UARF_PC_VIEW] ? fe_reg : sm0_reg,
                        sm1_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg,
                        ti_reg, ri_reg};
        `UARF_ADDR_SBUF: rdata_reg <= sbuf_reg;
        `UARF_ADDR_POWER_CONTROL_REG: rdata_reg <= power_control_reg_reg;
        `UARF_ADDR_BAUD_CONTROL_REG: rdata_reg <= {3'h0, baud_control_reg_reg};
        `UARF_ADDR_SLAVE_ADDRESS: rdata_reg <= slave_address_reg;
        `UARF_ADDR_SLAVE_ADDRESS_MASK: rdata_reg <= slave_address_mask_reg;
        `UARF_ADDR_IRQ_STAT: rdata_reg <= {5'h00, stat_reg};
        `UARF_ADDR_IRQ_MASK: rdata_reg <= {5'h00, mask_reg};
        `UARF_ADDR_TIMING: rdata_reg <= {7'h00, compat_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rdata_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_FE_SET: assert property (
    rx_final_reg && !rx_stop_reg |=> fe_reg)
    else $error("framing error flag not set");
  AST_BIT7_VIEW: assert property (
    bus_req.rd && bus_req.addr == `UARF_ADDR_SERIAL_CONTROL_REG && !wr_serial_control_reg |=>
    bus_rdata[7] == ($past(power_control_reg_reg[6]) ? $past(fe_reg) : $past(sm0_reg)))
    else $error("control bit 7 shows wrong view");
  AST_FE_HOLD: assert property (
    fe_reg && !(wr_serial_control_reg && power_control_reg_reg[`UARF_PC_VIEW]) |=> fe_reg)
    else $error("framing error flag cleared by hardware");
  AST_FE_ANY_VIEW: assert property (
    fe_set && !power_control_reg_reg[`UARF_PC_VIEW] && !wr_serial_control_reg
    |=> fe_reg && !$changed(sm0_reg))
    else $error("framing error lost in mode view");
  AST_M0_UNGATED: assert property (
    m0_rx_done && mpe_reg |=> ri_reg && sbuf_reg == $past(m0_sh_reg))
    else $error("mode 0 receive gated");
  AST_NINTH_DROP: assert property (
    rx_final_reg && mpe_reg && mode[1] && !rx_shift_reg[8] && !ri_reg
    && !wr_serial_control_reg |=> !ri_reg)
    else $error("data frame accepted under filtering");
  AST_NO_MATCH_DROP: assert property (
    rx_final_reg && mpe_reg && mode == UARF_MODE1 && !given_hit
    && !bcast_hit && !ri_reg && !wr_serial_control_reg |=> !ri_reg)
    else $error("unmatched address accepted");
  AST_FULL_KEEP: assert property (
    rx_final_reg && ri_reg && !m0_rx_done |=> $stable(sbuf_reg))
    else $error("buffer overwritten while flag set");
  AST_RESET_ADDR: assert property ($past(sys_rst) |->
    slave_address_reg == 8'h00 && slave_address_mask_reg == 8'h00)
    else $error("address registers not cleared");

  COV_ADDR_HIT: cover property (rx_load && filt_on);
  COV_M0_TX: cover property (m0_tx_done);
  COV_FE: cover property (fe_set ##1 irq);

endmodule

`default_nettype wire

//--- dv/uarf_node_model.sv
// far serial node: async frames and mode 0 slave data
`timescale 1ns/1ps
`default_nettype none

module uarf_node_model (
  input wire logic mclk,
  input wire logic tick,
  input wire logic sclk,
  output logic line
);
  // ****
  // line driving
  // ****
  initial line = 1'b1;

  // one bit cell is sixteen receive ticks
  task automatic hold(input logic b);
    line <= b;
    repeat (16) @(posedge mclk iff tick);
  endtask

  task automatic send(input logic [7:0] d, input logic has9,
    input logic n9, input logic stp);
    @(posedge mclk);
    hold(1'b0);
    for (int i = 0; i < 8; i++)
      hold(d[i]);
    if (has9)
      hold(n9);
    hold(stp);
    line <= 1'b1;
  endtask

  // next bit after each rising shift clock; inverse of last when released
  task automatic shift0(input logic [7:0] d);
    logic prev;
    int n;
    prev = 1'b1;
    n = 1;
    @(posedge mclk);
    line <= d[0];
    for (int c = 0; c < 400 && n <= 8; c++)
    begin
      @(posedge mclk);
      if (sclk && !prev)
      begin
        line <= (n < 8) ? d[n] : ~d[7];
        n++;
      end
      prev = sclk;
    end
  endtask
endmodule

`default_nettype wire

//--- dv/uarf_core_tb.sv
// self-checking bench for the serial port receive extensions
`include "uarf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module uarf_core_tb
  import uarf_pkg::*;
;
  logic mclk;
  logic sys_rst;
  uarf_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic rx_tick16;
  logic timer1_ovf;
  logic brg_ovf;
  logic rxd_o;
  logic rxd_oe;
  logic txd_o;
  logic irq;
  logic line;
  wire rxd_pin;
  int fail_count;
  int check_count;
  int cyc;
  logic [7:0] v;

  // the pin is whoever enables onto it
  assign rxd_pin = rxd_oe ? rxd_o : line;

  uarf_core uarf_core_i (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rx_tick16(rx_tick16), .timer1_ovf(timer1_ovf),
    .brg_ovf(brg_ovf), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
    .txd_o(txd_o), .irq(irq));

  uarf_node_model uarf_node_model_i (.mclk(mclk), .tick(rx_tick16),
    .sclk(txd_o), .line(line));

  // ****
  // clock and rate ticks
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // co-prime tick spacings keep every mode 0 source distinct
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rx_tick16 <= (cyc % 2 == 0);
    timer1_ovf <= (cyc % 3 == 0);
    brg_ovf <= (cyc % 5 == 0);
  end

  // ****
  // bus and check tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    // let the written register settle before anyone looks at outputs
    @(negedge mclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    v = bus_rdata;
    chk(v & m, e);
  endtask

  task automatic rxrow(input logic [7:0] sc, input logic [7:0] d,
    input logic n9, input logic stp, input logic e);
    wr(`UARF_ADDR_SERIAL_CONTROL_REG, sc);
    wr(`UARF_ADDR_IRQ_STAT, 8'h07);
    uarf_node_model_i.send(d, sc[7], n9, stp);
    repeat (12) @(posedge mclk);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h01, {7'h00, e});
    chk({7'h00, irq}, {7'h00, e});
    if (e)
      rc(`UARF_ADDR_SBUF, 8'hff, d);
  endtask

  task automatic m0row(input logic [7:0] pc, input logic [7:0] bd,
    input logic [7:0] tm, input logic [7:0] sc, input int per);
    int n;
    int t0;
    int t1;
    logic [7:0] got;
    wr(`UARF_ADDR_POWER_CONTROL_REG, pc);
    wr(`UARF_ADDR_BAUD_CONTROL_REG, bd);
    wr(`UARF_ADDR_TIMING, tm);
    wr(`UARF_ADDR_SERIAL_CONTROL_REG, sc);
    wr(`UARF_ADDR_SBUF, 8'h96);
    n = 0;
    t0 = 0;
    t1 = 0;
    got = 8'h00;
    for (int c = 0; c < 12 * per + 24; c++)
    begin
      @(negedge mclk);
      if (!txd_o && rxd_oe)
      begin
        if (n < 8)
          got[n] = rxd_o;
        if (n == 0)
          t0 = c;
        if (n == 1)
          t1 = c;
        n++;
      end
    end
    chk(8'(t1 - t0), 8'(per));
    chk(got, 8'h96);
    chk(8'(n), 8'h08);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h02, 8'h02);
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    sys_rst = 1'b1;
    bus_req = '0;
    cyc = 0;
    rx_tick16 = 1'b0;
    timer1_ovf = 1'b0;
    brg_ovf = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(`UARF_ADDR_SLAVE_ADDRESS, 8'hff, 8'h00);
    rc(`UARF_ADDR_SLAVE_ADDRESS_MASK, 8'hff, 8'h00);
    rc(8'hc5, 8'hff, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`UARF_ADDR_SLAVE_ADDRESS, 8'hc0);
    wr(`UARF_ADDR_SLAVE_ADDRESS_MASK, 8'hfd);
    rc(`UARF_ADDR_SLAVE_ADDRESS, 8'hff, 8'hc0);
    rc(`UARF_ADDR_SLAVE_ADDRESS_MASK, 8'hff, 8'hfd);
    wr(`UARF_ADDR_IRQ_MASK, 8'h01);
    rxrow(8'h50, 8'hc1, 1'b0, 1'b1, 1'b1);
    rxrow(8'h70, 8'hc2, 1'b0, 1'b1, 1'b1);
    rxrow(8'h70, 8'hc1, 1'b0, 1'b1, 1'b0);
    rxrow(8'h70, 8'hff, 1'b0, 1'b1, 1'b1);
    rxrow(8'h70, 8'hc2, 1'b0, 1'b0, 1'b0);
    rxrow(8'hf0, 8'hc2, 1'b1, 1'b1, 1'b1);
    rxrow(8'hf0, 8'hc2, 1'b0, 1'b1, 1'b0);
    rxrow(8'hf0, 8'hc1, 1'b1, 1'b1, 1'b0);
    rxrow(8'hb0, 8'hfd, 1'b1, 1'b1, 1'b1);
    rxrow(8'h50, 8'h3c, 1'b0, 1'b1, 1'b1);
    uarf_node_model_i.send(8'ha5, 1'b0, 1'b0, 1'b1);
    repeat (12) @(posedge mclk);
    rc(`UARF_ADDR_SBUF, 8'hff, 8'h3c);
    // missing stop bit while bit 7 shows the mode
    wr(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h50);
    wr(`UARF_ADDR_IRQ_STAT, 8'h07);
    wr(`UARF_ADDR_IRQ_MASK, 8'h00);
    uarf_node_model_i.send(8'h55, 1'b0, 1'b0, 1'b0);
    repeat (12) @(posedge mclk);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rc(`UARF_ADDR_IRQ_STAT, 8'h07, 8'h05);
    wr(`UARF_ADDR_POWER_CONTROL_REG, 8'h40);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
    wr(`UARF_ADDR_IRQ_MASK, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wr(`UARF_ADDR_IRQ_STAT, 8'h04);
    chk({7'h00, irq}, 8'h00);
    uarf_node_model_i.send(8'h0f, 1'b0, 1'b0, 1'b1);
    repeat (12) @(posedge mclk);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
    wr(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h50);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'hc0, 8'h40);
    // mode 0 transmit rates, timer every 3 and generator every 5 cycles
    m0row(8'h00, 8'h00, 8'h00, 8'h00, 4);
    m0row(8'h80, 8'h00, 8'h00, 8'h00, 2);
    m0row(8'h00, 8'h00, 8'h01, 8'h00, 6);
    m0row(8'h80, 8'h00, 8'h01, 8'h00, 3);
    m0row(8'h00, 8'h00, 8'h00, 8'h08, 12);
    m0row(8'h80, 8'h00, 8'h00, 8'h08, 6);
    m0row(8'h00, 8'h01, 8'h00, 8'h08, 10);
    m0row(8'h80, 8'h01, 8'h00, 8'h00, 5);
    // mode 0 receive with multiprocessor enable set
    wr(`UARF_ADDR_POWER_CONTROL_REG, 8'h00);
    wr(`UARF_ADDR_BAUD_CONTROL_REG, 8'h00);
    wr(`UARF_ADDR_IRQ_MASK, 8'h01);
    wr(`UARF_ADDR_IRQ_STAT, 8'h07);
    fork
      uarf_node_model_i.shift0(8'h5a);
      wr(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h30);
    join
    repeat (12) @(posedge mclk);
    rc(`UARF_ADDR_SERIAL_CONTROL_REG, 8'h01, 8'h01);
    rc(`UARF_ADDR_SBUF, 8'hff, 8'h5a);
    chk({7'h00, irq}, 8'h01);
    wrap_up();
  end
endmodule

`default_nettype wire
